// ---- logic/spims_pkg.sv ----
// spims_pkg: constants, register map and shared types of the spi block
// Function
// [RULE_01] Bit rate at most bus clock over two as master, four as slave.
// [RULE_02] Pin input filters default on, limit rate; clear enable for speed.
// [RULE_03] Wait mode with stop-in-wait clear behaves exactly like run mode.
// [RULE_04] Stop-in-wait set: master pauses then resumes, slave shifts on.
// [RULE_05] Light stop: master suspends its transfer, slave stays in step.
// [RULE_06] Deep stop disables the block and returns all registers to reset.
// [RULE_07] Only the master starts transfers, sending on MOSI, sampling MISO.
// [RULE_08] A transfer swaps master and slave shift register contents.
// [RULE_09] External master holds select low so the slave takes part.
// [RULE_10] Transmit buffer word moves to the shifter when a transfer begins.
// [RULE_11] After 8 or 16 bits the word moves into the receive buffer.
// [RULE_12] Master drives its clock on the clock pin, sends MOSI, takes MISO.
// [RULE_13] Slave clocks from the clock pin, sends MISO, takes MOSI.
// [RULE_14] Match flag sets when the receive buffer equals the match value.
// [RULE_15] Software starts a master transfer after seeing transmit empty.
// [RULE_16] Software waits for receive full to read, transmit empty to write.
// [RULE_17] Optional mode fault detection as master flags a second master.
// [RULE_18] Shift order selects MSB first or LSB first.
// [RULE_19] Full duplex on two lines or single-wire bidirectional data.
// [RULE_20] Serial clock polarity and phase are selectable.
// [RULE_21] Clearing system enable forces idle and resets every status flag.
// [RULE_22] Clock polarity 0 idles low, polarity 1 idles high.
// [RULE_23] Master rate comes from a prescaler followed by a further divider.
package spims_pkg;

    // ********************************
    // timing
    // ********************************
    localparam int CLK_HZ = 100000000;
    localparam int FILT_LIMIT_HZ = 6000000;
    localparam int FILT_CYC = CLK_HZ / (FILT_LIMIT_HZ * 4);

    // ********************************
    // register word indices (byte address / 4)
    // ********************************
    localparam logic [3:0] IDX_CTRL1 = 4'h0;
    localparam logic [3:0] IDX_CTRL2 = 4'h1;
    localparam logic [3:0] IDX_BAUD = 4'h2;
    localparam logic [3:0] IDX_DATA_HI = 4'h3;
    localparam logic [3:0] IDX_DATA_LO = 4'h4;
    localparam logic [3:0] IDX_MATCH_HI = 4'h5;
    localparam logic [3:0] IDX_MATCH_LO = 4'h6;
    localparam logic [3:0] IDX_STATUS = 4'h7;
    localparam logic [3:0] IDX_OPTIONS = 4'h8;

    // ********************************
    // field positions
    // ********************************
    localparam int C1_SYS_EN = 6;
    localparam int C1_MASTER = 4;
    localparam int C1_CPOL = 3;
    localparam int C1_CPHA = 2;
    localparam int C1_SS_OE = 1;
    localparam int C1_LSB = 0;
    localparam int C2_WORD16 = 6;
    localparam int C2_MODE_FAULT_FLAG_EN = 4;
    localparam int C2_BIDIR_OE = 3;
    localparam int C2_STOP_WAIT = 1;
    localparam int C2_SINGLE = 0;
    localparam int ST_RX_FULL = 7;
    localparam int ST_MATCH = 6;
    localparam int ST_TX_EMPTY = 5;
    localparam int ST_MODE_FAULT_FLAG = 4;
    localparam int OPT_FILTER = 0;
    localparam int BR_PRE_LSB = 4;
    localparam int BR_DIV_LSB = 0;

    // ********************************
    // reset values and counts
    // ********************************
    localparam logic [7:0] CTRL1_RST = 8'h04;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'h00;
    localparam logic [7:0] OPTIONS_RST = 8'h01;
    localparam logic [5:0] EDGES_8 = 6'h10;
    localparam logic [5:0] EDGES_16 = 6'h20;

    typedef enum logic {SPIMS_IDLE, SPIMS_RUN} spims_state_t;

endpackage : spims_pkg

// ---- logic/spims_pin_in.sv ----
// spims_pin_in: two-flop synchroniser plus optional glitch filter
`timescale 1ns/1ns
module spims_pin_in #(
    parameter int FILT_CYC = 4,
    parameter logic RST_LVL = 1'b0
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // control
    input wire logic filt_en_in,
    // pin and filtered level
    input wire logic pin_in,
    output logic level_out
);
    logic s1_r;
    logic s2_r;
    logic lvl_r;
    logic [3:0] cnt_r;

    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            s1_r <= RST_LVL;
            s2_r <= RST_LVL;
        end
        else
        begin
            s1_r <= pin_in;
            s2_r <= s1_r;
        end
    end

    // a new level must hold for the filter span; costs latency
    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            lvl_r <= RST_LVL;
            cnt_r <= 4'h0;
        end
        else if (s2_r == lvl_r)
            cnt_r <= 4'h0;
        else if (!filt_en_in || cnt_r == 4'(FILT_CYC - 1)) // RULE_02
        begin
            lvl_r <= s2_r;
            cnt_r <= 4'h0;
        end
        else
            cnt_r <= cnt_r + 4'h1;
    end

    assign level_out = lvl_r;

endmodule : spims_pin_in

// ---- logic/spims_baud.sv ----
// spims_baud: prescaler and divider making half-bit ticks for the master
`timescale 1ns/1ns
module spims_baud (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // control
    input wire logic clr_in,
    input wire logic [2:0] pre_in,
    input wire logic [2:0] div_in,
    // half period strobe
    output logic tick_out
);
    logic [2:0] pre_cnt_r;
    logic [6:0] div_cnt_r;
    logic [7:0] span;
    logic [6:0] div_top;
    logic pre_hit;

    // prescale 1..8 then divide 2..256; half of the divide per tick
    assign span = 8'h01 << div_in;
    assign div_top = 7'(span - 8'h01);
    assign pre_hit = (pre_cnt_r == pre_in);
    assign tick_out = pre_hit && (div_cnt_r == div_top); // RULE_23

    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in || clr_in)
        begin
            pre_cnt_r <= 3'h0;
            div_cnt_r <= 7'h00;
        end
        else if (pre_hit)
        begin
            pre_cnt_r <= 3'h0;
            div_cnt_r <= tick_out ? 7'h00 : div_cnt_r + 7'h01;
        end
        else
            pre_cnt_r <= pre_cnt_r + 3'h1;
    end

endmodule : spims_baud

// ---- logic/spims_top.sv ----
// spims_top: spi master/slave core with avalon-mm register slave
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
module spims_top (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // avalon-mm slave
    input wire logic [5:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // cpu power state
    input wire logic cpu_wait_in,
    input wire logic cpu_stop3_in,
    input wire logic cpu_stop_deep_in,
    // serial clock pin
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe_out,
    // mosi pin
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe_out,
    // miso pin
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe_out,
    // slave select pin
    input wire logic ss_n_in,
    output logic ss_n_out,
    output logic ss_n_oe_out
);

    // ********************************
    // declarations
    // ********************************
    logic srst;
    logic ack_r;
    logic req;
    logic acc;
    logic wr;
    logic rd;
    logic [3:0] idx;
    logic [7:0] wd;
    logic [7:0] rmux;
    logic [31:0] rdata_r;
    logic [7:0] ctrl1_r;
    logic [7:0] ctrl2_r;
    logic [7:0] baud_r;
    logic [7:0] opt_r;
    logic [7:0] tx_hi_r;
    logic [15:0] tx_buf_r;
    logic [15:0] rx_buf_r;
    logic [15:0] match_r;
    logic tx_empty_r;
    logic rx_full_r;
    logic match_flag_r;
    logic mode_fault_flag_r;
    spims_pkg::spims_state_t st_r;
    logic [15:0] shift_r;
    logic [5:0] edge_cnt_r;
    logic pend_r;
    logic pbit_r;
    logic sclk_r;
    logic sclk_prev_r;
    logic sclk_f;
    logic mosi_f;
    logic miso_f;
    logic ss_f;
    logic tick;
    logic en;
    logic master;
    logic w16;
    logic sw;
    logic cpha;
    logic lsb;
    logic pause;
    logic run;
    logic start;
    logic edge_ev;
    logic lead;
    logic smp_ev;
    logic sft_ev;
    logic last_ev;
    logic mode_fault_flag_ev;
    logic din;
    logic dbit;
    logic [5:0] edges;
    logic [15:0] word;
    logic [15:0] word_m;

    function automatic logic [15:0] shin(input logic [15:0] sh,
        input logic b, input logic lsb_f, input logic w16_f);
        if (!lsb_f)
            shin = {sh[14:0], b};
        else if (w16_f)
            shin = {b, sh[15:1]};
        else
            shin = {8'h00, b, sh[7:1]};
    endfunction : shin

    // deep stop holds all but the bus port and pin filters in reset until wake
    assign srst = !nrst_in || cpu_stop_deep_in; // RULE_06

    // ********************************
    // avalon-mm slave: one wait state per access
    // ********************************
    assign req = avs_read_in || avs_write_in;
    assign acc = req && ack_r;
    assign avs_waitrequest_out = req && !ack_r;
    assign avs_readdata_out = rdata_r;
    assign idx = avs_address_in[5:2];
    assign wd = avs_writedata_in[7:0];
    assign wr = acc && avs_write_in && avs_byteenable_in[0];
    assign rd = acc && avs_read_in;

    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
            ack_r <= 1'b0;
        else
            ack_r <= req && !ack_r;
    end

    always_comb
    begin
        rmux = 8'h00;
        case (idx)
            spims_pkg::IDX_CTRL1: rmux = ctrl1_r;
            spims_pkg::IDX_CTRL2: rmux = ctrl2_r;
            spims_pkg::IDX_BAUD: rmux = baud_r;
            spims_pkg::IDX_DATA_HI: rmux = w16 ? rx_buf_r[15:8] : 8'h00;
            spims_pkg::IDX_DATA_LO: rmux = rx_buf_r[7:0];
            spims_pkg::IDX_MATCH_HI: rmux = match_r[15:8];
            spims_pkg::IDX_MATCH_LO: rmux = match_r[7:0];
            spims_pkg::IDX_STATUS:
            begin
                rmux[spims_pkg::ST_RX_FULL] = rx_full_r;
                rmux[spims_pkg::ST_MATCH] = match_flag_r;
                rmux[spims_pkg::ST_TX_EMPTY] = tx_empty_r;
                rmux[spims_pkg::ST_MODE_FAULT_FLAG] = mode_fault_flag_r;
            end
            spims_pkg::IDX_OPTIONS: rmux = opt_r;
            default: rmux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
            rdata_r <= 32'h0000_0000;
        else if (req && !ack_r)
            rdata_r <= {24'h00_0000, rmux};
    end

    // ********************************
    // control registers
    // ********************************
    always_ff @(posedge clk_sys_in)
    begin
        if (srst)
            ctrl1_r <= spims_pkg::CTRL1_RST;
        else
        begin
            if (wr && idx == spims_pkg::IDX_CTRL1)
                ctrl1_r <= wd;
            // a second master drops this end back to slave
            if (mode_fault_flag_ev)
                ctrl1_r[spims_pkg::C1_MASTER] <= 1'b0; // RULE_17
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (srst)
        begin
            ctrl2_r <= spims_pkg::CTRL2_RST;
            baud_r <= spims_pkg::BAUD_RST;
            opt_r <= spims_pkg::OPTIONS_RST; // RULE_02
            match_r <= 16'h0000;
            tx_hi_r <= 8'h00;
            tx_buf_r <= 16'h0000;
        end
        else if (wr)
        begin
            case (idx)
                spims_pkg::IDX_CTRL2: ctrl2_r <= wd;
                spims_pkg::IDX_BAUD: baud_r <= wd;
                spims_pkg::IDX_OPTIONS: opt_r <= wd;
                spims_pkg::IDX_MATCH_HI: match_r[15:8] <= wd;
                spims_pkg::IDX_MATCH_LO: match_r[7:0] <= wd;
                spims_pkg::IDX_DATA_HI: tx_hi_r <= wd;
                spims_pkg::IDX_DATA_LO: tx_buf_r <= {tx_hi_r, wd};
                default: tx_hi_r <= tx_hi_r;
            endcase
        end
    end

    assign en = ctrl1_r[spims_pkg::C1_SYS_EN];
    assign master = ctrl1_r[spims_pkg::C1_MASTER];
    assign cpha = ctrl1_r[spims_pkg::C1_CPHA]; // RULE_20
    assign lsb = ctrl1_r[spims_pkg::C1_LSB];
    assign w16 = ctrl2_r[spims_pkg::C2_WORD16];
    assign sw = ctrl2_r[spims_pkg::C2_SINGLE];

    // ********************************
    // pin inputs and rate generator
    // ********************************
    spims_pin_in #(.FILT_CYC(spims_pkg::FILT_CYC), .RST_LVL(1'b0)) u_sclk (
        .clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .filt_en_in(opt_r[spims_pkg::OPT_FILTER]),
        .pin_in(sclk_in), .level_out(sclk_f));
    spims_pin_in #(.FILT_CYC(spims_pkg::FILT_CYC), .RST_LVL(1'b0)) u_mosi (
        .clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .filt_en_in(opt_r[spims_pkg::OPT_FILTER]),
        .pin_in(mosi_in), .level_out(mosi_f));
    spims_pin_in #(.FILT_CYC(spims_pkg::FILT_CYC), .RST_LVL(1'b0)) u_miso (
        .clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .filt_en_in(opt_r[spims_pkg::OPT_FILTER]),
        .pin_in(miso_in), .level_out(miso_f));
    spims_pin_in #(.FILT_CYC(spims_pkg::FILT_CYC), .RST_LVL(1'b1)) u_ss (
        .clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .filt_en_in(opt_r[spims_pkg::OPT_FILTER]),
        .pin_in(ss_n_in), .level_out(ss_f));

    // fastest setting toggles every cycle: bus clock over two
    spims_baud u_baud (
        .clk_sys_in(clk_sys_in), .nrst_in(!srst), .clr_in(!run),
        .pre_in(baud_r[spims_pkg::BR_PRE_LSB +: 3]),
        .div_in(baud_r[spims_pkg::BR_DIV_LSB +: 3]),
        .tick_out(tick)); // RULE_01

    // ********************************
    // transfer engine
    // ********************************
    // plain wait leaves the engine running; only a master pauses
    assign pause = master && (cpu_stop3_in || (cpu_wait_in && // RULE_05
        ctrl2_r[spims_pkg::C2_STOP_WAIT])); // RULE_03 RULE_04
    assign run = (st_r == spims_pkg::SPIMS_RUN);
    assign mode_fault_flag_ev = en && master && ctrl2_r[spims_pkg::C2_MODE_FAULT_FLAG_EN] &&
        !ctrl1_r[spims_pkg::C1_SS_OE] && !ss_f; // RULE_17
    // master needs a queued word; slave starts on select low
    assign start = en && !run && !mode_fault_flag_ev &&
        (master ? (!tx_empty_r && !pause) : !ss_f); // RULE_07 RULE_09
    // slave edges are synchronised, so the pin must run at most clk/4
    assign edge_ev = run && (master ? (tick && !pause)
        : (sclk_f != sclk_prev_r)); // RULE_01 RULE_04 RULE_05 RULE_13
    assign lead = !edge_cnt_r[0];
    assign smp_ev = edge_ev && (lead ^ cpha);
    assign sft_ev = edge_ev && !(lead ^ cpha) && pend_r;
    assign edges = w16 ? spims_pkg::EDGES_16 : spims_pkg::EDGES_8;
    assign last_ev = edge_ev && (edge_cnt_r == edges - 6'h01);
    assign din = master ? (sw ? mosi_f : miso_f)
        : (sw ? miso_f : mosi_f); // RULE_12 RULE_13 RULE_19
    assign dbit = lsb ? shift_r[0]
        : (w16 ? shift_r[15] : shift_r[7]); // RULE_18
    // cpha 1 samples on the last edge, so the final bit comes from the pin
    assign word = shin(shift_r, cpha ? din : pbit_r, lsb, w16); // RULE_08
    assign word_m = w16 ? word : {8'h00, word[7:0]};

    always_ff @(posedge clk_sys_in)
    begin
        if (srst)
            sclk_prev_r <= 1'b0;
        else
            sclk_prev_r <= sclk_f;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (srst)
        begin
            st_r <= spims_pkg::SPIMS_IDLE;
            shift_r <= 16'h0000;
            edge_cnt_r <= 6'h00;
            pend_r <= 1'b0;
            pbit_r <= 1'b0;
            sclk_r <= 1'b0;
        end
        else if (!en || mode_fault_flag_ev)
        begin
            st_r <= spims_pkg::SPIMS_IDLE; // RULE_21
            edge_cnt_r <= 6'h00;
            pend_r <= 1'b0;
            sclk_r <= ctrl1_r[spims_pkg::C1_CPOL]; // RULE_22
        end
        else
        begin
            case (st_r)
                spims_pkg::SPIMS_IDLE:
                begin
                    sclk_r <= ctrl1_r[spims_pkg::C1_CPOL]; // RULE_22
                    edge_cnt_r <= 6'h00;
                    pend_r <= 1'b0;
                    if (start)
                    begin
                        shift_r <= tx_buf_r; // RULE_10
                        st_r <= spims_pkg::SPIMS_RUN;
                    end
                end
                spims_pkg::SPIMS_RUN:
                begin
                    if (!master && ss_f)
                        st_r <= spims_pkg::SPIMS_IDLE;
                    else if (edge_ev)
                    begin
                        edge_cnt_r <= edge_cnt_r + 6'h01;
                        if (master)
                            sclk_r <= !sclk_r; // RULE_12
                        if (smp_ev)
                        begin
                            pbit_r <= din;
                            pend_r <= 1'b1;
                        end
                        if (sft_ev)
                        begin
                            shift_r <= shin(shift_r, pbit_r, lsb, w16);
                            pend_r <= 1'b0;
                        end
                        if (last_ev)
                            st_r <= spims_pkg::SPIMS_IDLE; // RULE_11
                    end
                end
                default: st_r <= spims_pkg::SPIMS_IDLE;
            endcase
        end
    end

    // ********************************
    // status flags: hardware set wins over clear
    // ********************************
    always_ff @(posedge clk_sys_in)
    begin
        if (srst || !en)
            tx_empty_r <= 1'b1; // RULE_21
        else if (start)
            tx_empty_r <= 1'b1; // RULE_10
        else if (wr && idx == spims_pkg::IDX_DATA_LO)
            tx_empty_r <= 1'b0;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (srst)
            rx_buf_r <= 16'h0000;
        else if (last_ev)
            rx_buf_r <= word_m; // RULE_11
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (srst || !en)
        begin
            rx_full_r <= 1'b0; // RULE_21
            match_flag_r <= 1'b0;
        end
        else if (last_ev)
        begin
            rx_full_r <= 1'b1; // RULE_11
            match_flag_r <= (word_m == match_r); // RULE_14
        end
        else if (rd && idx == spims_pkg::IDX_DATA_LO)
        begin
            rx_full_r <= 1'b0;
            match_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (srst || !en)
            mode_fault_flag_r <= 1'b0; // RULE_21
        else if (mode_fault_flag_ev)
            mode_fault_flag_r <= 1'b1; // RULE_17
        else if (wr && idx == spims_pkg::IDX_CTRL1)
            mode_fault_flag_r <= 1'b0;
    end

    // ********************************
    // pin drivers, registered
    // ********************************
    always_ff @(posedge clk_sys_in)
    begin
        if (srst)
        begin
            sclk_out <= 1'b0;
            sclk_oe_out <= 1'b0;
            mosi_out <= 1'b0;
            mosi_oe_out <= 1'b0;
            miso_out <= 1'b0;
            miso_oe_out <= 1'b0;
            ss_n_out <= 1'b1;
            ss_n_oe_out <= 1'b0;
        end
        else
        begin
            sclk_out <= sclk_r;
            sclk_oe_out <= en && master; // RULE_12
            mosi_out <= dbit;
            mosi_oe_out <= en && master &&
                (!sw || ctrl2_r[spims_pkg::C2_BIDIR_OE]); // RULE_12 RULE_19
            miso_out <= dbit;
            miso_oe_out <= en && !master && !ss_f &&
                (!sw || ctrl2_r[spims_pkg::C2_BIDIR_OE]); // RULE_13 RULE_19
            ss_n_out <= !(run && master); // RULE_07
            ss_n_oe_out <= en && master && ctrl2_r[spims_pkg::C2_MODE_FAULT_FLAG_EN] &&
                ctrl1_r[spims_pkg::C1_SS_OE];
        end
    end

endmodule : spims_top

// ---- verif/spims_top_asserts.sv ----
// spims_top_asserts: port checks for spims_top
`timescale 1ns/1ns
module spims_top_asserts (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // watched ports
    input wire logic avs_write_in,
    input wire logic cpu_stop3_in,
    input wire logic cpu_stop_deep_in,
    input wire logic sclk_out,
    input wire logic sclk_oe_out,
    input wire logic mosi_oe_out,
    input wire logic miso_oe_out,
    input wire logic ss_n_out
);
    // ****
    // clock edges per frame
    // ****
    logic sclk_q_r;
    logic ss_q_r;
    logic [5:0] edges_r;
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);
    always_ff @(posedge clk_sys_in)
    begin
        sclk_q_r <= sclk_out;
        ss_q_r <= ss_n_out;
        if (!nrst_in || (!ss_n_out && ss_q_r))
        begin
            edges_r <= 6'h00;
        end
        else if (sclk_out != sclk_q_r)
        begin
            edges_r <= edges_r + 6'h01;
        end
    end
    chk_master_no_miso: assert property (
        sclk_oe_out |-> !miso_oe_out) else $error("master drives miso");
    chk_slave_pins_in: assert property (
        miso_oe_out |-> !sclk_oe_out && !mosi_oe_out)
        else $error("slave drives clock or mosi");
    chk_data_one_way: assert property (
        mosi_oe_out |-> !miso_oe_out) else $error("both data lines driven");
    chk_select_by_master: assert property (
        $fell(ss_n_out) |-> sclk_oe_out) else $error("frame without master");
    chk_deep_idle: assert property (
        cpu_stop_deep_in |=> !sclk_oe_out && !mosi_oe_out && !miso_oe_out
        && ss_n_out) else $error("pins active in deep stop");
    chk_stop_freeze: assert property (
        cpu_stop3_in && $past(cpu_stop3_in) && $past(cpu_stop3_in, 2)
        && $past(cpu_stop3_in, 3) && sclk_oe_out |-> $stable(sclk_out))
        else $error("clock moved in light stop");
    chk_frame_edges: assert property (
        $rose(ss_n_out) |=> ##1 (edges_r == 6'h10 || edges_r == 6'h20))
        else $error("wrong clock edge count in frame");
    chk_idle_clock_still: assert property (
        sclk_oe_out && ss_n_out && $past(ss_n_out) && $past(ss_n_out, 2)
        && !$past(avs_write_in) && !$past(avs_write_in, 2)
        && !$past(avs_write_in, 3) |-> $stable(sclk_out))
        else $error("clock moved while idle");
endmodule : spims_top_asserts
bind spims_top spims_top_asserts u_chk (.clk_sys_in, .nrst_in,
    .avs_write_in, .cpu_stop3_in, .cpu_stop_deep_in, .sclk_out,
    .sclk_oe_out, .mosi_oe_out, .miso_oe_out, .ss_n_out);

// ---- verif/spims_slave_model.sv ----
// spims_slave_model: behavioural spi slave, clock polarity 0, phase 0
`timescale 1ns/1ns
module spims_slave_model (
    // serial pins
    input wire logic sclk_in,
    input wire logic mosi_in,
    input wire logic ss_n_in,
    output logic miso_out,
    // bench side
    input wire logic [7:0] load_in,
    output logic [7:0] got_out
);
    logic [7:0] sr = 8'h00;
    logic bit_q = 1'b0;
    initial got_out = 8'h00;
    always @(negedge ss_n_in) {sr, bit_q} = {load_in, load_in[7]};
    // shift on the rising edge: select may rise with the last fall
    always @(posedge sclk_in) if (!ss_n_in) sr = {sr[6:0], mosi_in};
    always @(negedge sclk_in) if (!ss_n_in) bit_q = sr[7];
    always @(posedge ss_n_in) got_out = sr;
    // released line inverts so a late sample cannot pass by luck
    assign miso_out = ss_n_in ? ~bit_q : bit_q;
endmodule : spims_slave_model

// ---- verif/spi_8_16_bit_master_slave_test.sv ----
// spi_8_16_bit_master_slave_test: self-checking bench for spims_top
`timescale 1ns/1ns
module spi_8_16_bit_master_slave_test;
    logic clk_sys_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [5:0] addr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic cpu_wait = 1'b0;
    logic stop3 = 1'b0;
    logic deep = 1'b0;
    logic ss_drv = 1'b1;
    logic [7:0] load = 8'h00;
    logic [31:0] rdata, q;
    logic waitreq, sclk, sclk_oe, mosi, mosi_oe, miso_d, miso_oe, miso_m, ss_n;
    logic [7:0] got;
    int miscompares = 0;
    int checks_done = 0;
    always #5 clk_sys_in = ~clk_sys_in;
    spims_top dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_byteenable_in(4'hF), .avs_writedata_in(wdata),
        .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
        .cpu_wait_in(cpu_wait), .cpu_stop3_in(stop3),
        .cpu_stop_deep_in(deep), .sclk_in(sclk_oe ? sclk : 1'b0),
        .sclk_out(sclk), .sclk_oe_out(sclk_oe),
        .mosi_in(mosi_oe ? mosi : 1'b0), .mosi_out(mosi),
        .mosi_oe_out(mosi_oe), .miso_in(miso_oe ? miso_d : miso_m),
        .miso_out(miso_d), .miso_oe_out(miso_oe), .ss_n_in(ss_drv),
        .ss_n_out(ss_n), .ss_n_oe_out());
    spims_slave_model peer (.sclk_in(sclk), .mosi_in(mosi), .ss_n_in(ss_n),
        .miso_out(miso_m), .load_in(load), .got_out(got));
    task automatic complete_run;
        if (miscompares == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // ****
    // avalon master: hold until waitrequest is seen low
    // ****
    task automatic bus(input logic w, input logic [5:0] a,
        input logic [7:0] d);
        @(posedge clk_sys_in);
        addr <= a;
        wdata <= {24'h000000, d};
        rd <= ~w;
        wr <= w;
        @(posedge clk_sys_in);
        while (waitreq !== 1'b0) @(posedge clk_sys_in);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic rdc(input logic [5:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, {24'h000000, e});
    endtask : rdc
    task automatic regs_reset;
        rdc(6'h00, 8'h04);
        rdc(6'h04, 8'h00);
        rdc(6'h08, 8'h00);
        rdc(6'h1C, 8'h20);
        rdc(6'h20, 8'h01);
        rdc(6'h24, 8'h00);
    endtask : regs_reset
    // ****
    // one master frame against the model
    // ****
    task automatic xfer(input logic [7:0] c1, tx, sl, rx, st, pk,
                        input logic pause);
        logic s;
        bus(1'b1, 6'h00, c1);
        bus(1'b1, 6'h08, 8'h13);
        load <= sl;
        bus(1'b1, 6'h10, tx);
        if (pause)
        begin
            repeat (100) @(posedge clk_sys_in);
            stop3 <= 1'b1;
            repeat (4) @(posedge clk_sys_in);
            s = sclk;
            repeat (48) @(posedge clk_sys_in);
            chk({30'h0, sclk, ss_n}, {30'h0, s, 1'b0});
            rdc(6'h1C, 8'h20);
            stop3 <= 1'b0;
        end
        q = 32'h00000000;
        for (int n = 0; n < 400 && q[7] !== 1'b1; n++)
            bus(1'b0, 6'h1C, 8'h00);
        chk(q, {24'h000000, st});
        rdc(6'h10, rx);
        chk({24'h000000, got}, {24'h000000, pk});
    endtask : xfer
    initial
    begin
        repeat (30000) @(posedge clk_sys_in);
        miscompares++;
        complete_run;
    end
    initial
    begin
        repeat (20) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        regs_reset;
        bus(1'b1, 6'h14, 8'h00);
        bus(1'b1, 6'h18, 8'h3C);
        cpu_wait <= 1'b1;
        xfer(8'h50, 8'hA5, 8'h3C, 8'h3C, 8'hE0, 8'hA5, 1'b0);
        cpu_wait <= 1'b0;
        xfer(8'h51, 8'h12, 8'h80, 8'h01, 8'hA0, 8'h48, 1'b0);
        xfer(8'h50, 8'h5A, 8'hC3, 8'hC3, 8'hA0, 8'h5A, 1'b1);
        bus(1'b1, 6'h04, 8'h40);
        bus(1'b1, 6'h0C, 8'h96);
        xfer(8'h50, 8'h69, 8'h0F, 8'h96, 8'hA0, 8'h69, 1'b0);
        rdc(6'h0C, 8'h0F);
        bus(1'b1, 6'h04, 8'h00);
        bus(1'b1, 6'h00, 8'h58);
        repeat (4) @(posedge clk_sys_in);
        chk({30'h0, sclk_oe, sclk}, {30'h0, 2'b11});
        bus(1'b1, 6'h00, 8'h50);
        repeat (4) @(posedge clk_sys_in);
        chk({30'h0, sclk_oe, sclk}, {30'h0, 2'b10});
        bus(1'b1, 6'h04, 8'h10);
        ss_drv <= 1'b0;
        repeat (20) @(posedge clk_sys_in);
        rdc(6'h1C, 8'h30);
        rdc(6'h00, 8'h40);
        ss_drv <= 1'b1;
        repeat (10) @(posedge clk_sys_in);
        bus(1'b1, 6'h00, 8'h50);
        bus(1'b1, 6'h10, 8'h11);
        repeat (400) @(posedge clk_sys_in);
        rdc(6'h1C, 8'hA0);
        bus(1'b1, 6'h00, 8'h00);
        rdc(6'h1C, 8'h20);
        bus(1'b1, 6'h08, 8'h13);
        deep <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        deep <= 1'b0;
        regs_reset;
        complete_run;
    end
endmodule : spi_8_16_bit_master_slave_test
